// ### core/bus_cycle_engine.sv
// One read or write strobe on the flash pins, four phases of 16 cycles
`timescale 1ns/100ps
module bus_cycle_engine
	import flash_host_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rst,
	bus_cycle_if.eng   cyc,
	input  wire logic [7:0] dataInSync,
	output logic [17:0] addrPin,
	output logic [7:0]  dataOut,
	output logic        dataOe,
	output logic        chipEnableN,
	output logic        outEnableN,
	output logic        writeEnableN
);
	logic [1:0] phase;
	logic [3:0] tick;
	logic       busy;
	logic       wr;
	wire        phaseEnd = (tick == 4'hF);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			phase <= PH_SETUP;
			tick <= 4'h0;
			wr <= 1'b0;
			addrPin <= '0;
			dataOut <= 8'h00;
			dataOe <= 1'b0;
			chipEnableN <= 1'b1;
			outEnableN <= 1'b1;
			writeEnableN <= 1'b1;
			cyc.done <= 1'b0;
			cyc.rdata <= 8'h00;
		end else begin
			cyc.done <= 1'b0;
			if (!busy && cyc.start) begin
				busy <= 1'b1;
				phase <= PH_SETUP;
				tick <= 4'h0;
				wr <= cyc.isWrite;
				addrPin <= cyc.addr;
				dataOut <= cyc.wdata;
				dataOe <= cyc.isWrite;
				chipEnableN <= 1'b0;
			end else if (busy) begin
				tick <= tick + 4'h1;
				if (phaseEnd) begin
					phase <= phase + 2'h1;
					case (phase)
						PH_SETUP: begin
							if (wr) writeEnableN <= 1'b0;
							else outEnableN <= 1'b0;
						end
						PH_STROBE: begin
							if (!wr) cyc.rdata <= dataInSync;
							writeEnableN <= 1'b1;
							outEnableN <= 1'b1;
						end
						PH_HOLD: begin
							chipEnableN <= 1'b1;
							dataOe <= 1'b0;
						end
						PH_LAST: begin
							busy <= 1'b0;
							cyc.done <= 1'b1;
						end
						default: busy <= 1'b0;
					endcase
				end
			end
		end
	end
	chk_oe_we_excl: assert property (@(posedge clk) disable iff (rst)
		!(!outEnableN && !writeEnableN))
		else $error("output and write enable both low");
	chk_drive_write: assert property (@(posedge clk) disable iff (rst)
		!writeEnableN |-> dataOe && !chipEnableN)
		else $error("write strobe without data drive");
	chk_done_timing: assert property (@(posedge clk) disable iff (rst)
		(!busy && cyc.start) |-> ##65 cyc.done)
		else $error("bus cycle length wrong");
endmodule : bus_cycle_engine

// ### core/bus_cycle_if.sv
// Handshake between sequencer and pin cycle engine
`timescale 1ns/100ps
interface bus_cycle_if;
	logic        start;
	logic        isWrite;
	logic [17:0] addr;
	logic [7:0]  wdata;
	logic        done;
	logic [7:0]  rdata;
	modport seq (output start, isWrite, addr, wdata, input done, rdata);
	modport eng (input start, isWrite, addr, wdata, output done, rdata);
endinterface : bus_cycle_if

// ### core/flash_host_pkg.sv
// Constants for the sector flash host controller
// Functional notes
// - The host keeps address bits 17..8 at the sector address on every write strobe of a sector load.
// - The host issues each byte load within 150 us of the previous one.
// - After a protection sequence the host loads a full sector of 256 bytes.
// - The host presents command data on the eight data lines and command addresses on bits 14..0.
// - The host detects completion only when the toggle status bit stops changing between reads.
// - The host polls at one fixed address for all status reads.
package flash_host_pkg;
	localparam int ADDR_W       = 18;
	localparam int SECTOR_LSB   = 8;
	localparam int SECTOR_BYTES = 256;
	localparam int CLK_MHZ      = 125;
	localparam int BLC_US       = 150;
	localparam int BLC_CYC      = BLC_US * CLK_MHZ;
	localparam int LOAD_GAP_US  = 100;
	localparam int LOAD_GAP_CYC = LOAD_GAP_US * CLK_MHZ;
	localparam int WC_MS        = 10;
	localparam int WC_CYC       = WC_MS * 1000 * CLK_MHZ;
	localparam int TOGGLE_BIT   = 6;
	localparam int CMD_ADDR_W   = 15;
	localparam logic [14:0] CMD_ADDR_A = 15'h5555;
	localparam logic [14:0] CMD_ADDR_B = 15'h2AAA;
	localparam logic [7:0]  CMD_DATA_A = 8'hAA;
	localparam logic [7:0]  CMD_DATA_B = 8'h55;
	localparam logic [7:0]  CMD_PROT_ON  = 8'hA0;
	localparam logic [7:0]  CMD_PROT_OFF = 8'h20;
	localparam logic [7:0]  CMD_ID_IN    = 8'h90;
	localparam logic [7:0]  CMD_ID_OUT   = 8'hF0;
	localparam logic [7:0]  CMD_BOOT     = 8'h80;
	localparam logic [7:0]  CMD_BOOT_LO  = 8'h00;
	localparam logic [7:0]  CMD_BOOT_HI  = 8'hFF;
	localparam logic [2:0]  OP_READ    = 3'h0;
	localparam logic [2:0]  OP_PROG    = 3'h1;
	localparam logic [2:0]  OP_PROT_ON = 3'h2;
	localparam logic [2:0]  OP_PROT_OFF= 3'h3;
	localparam logic [2:0]  OP_ID_IN   = 3'h4;
	localparam logic [2:0]  OP_ID_OUT  = 3'h5;
	localparam logic [2:0]  OP_BOOT_LO = 3'h6;
	localparam logic [2:0]  OP_BOOT_HI = 3'h7;
	localparam logic [1:0]  PH_SETUP  = 2'h0;
	localparam logic [1:0]  PH_STROBE = 2'h1;
	localparam logic [1:0]  PH_HOLD   = 2'h2;
	localparam logic [1:0]  PH_LAST   = 2'h3;
endpackage : flash_host_pkg

// ### core/sector_flash_host.sv
// Host sequencer: commands, sector loads, toggle polling
`timescale 1ns/100ps
module sector_flash_host
	import flash_host_pkg::*;
#(
	parameter int BLC_CYCLES = BLC_CYC,
	parameter int GAP_CYCLES = LOAD_GAP_CYC,
	parameter int WC_CYCLES  = WC_CYC
)(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        reqValid,
	input  wire logic [2:0]  reqOp,
	input  wire logic [17:0] reqAddr,
	input  wire logic [7:0]  reqData,
	output logic        reqReady,
	output logic        dataReq,
	input  wire logic [7:0]  dataByte,
	output logic        rspValid,
	output logic [7:0]  rspData,
	output logic        rspTimeout,
	output logic [17:0] flashAddr,
	output logic [7:0]  flashDataOut,
	output logic        flashDataOe,
	input  wire logic [7:0]  flashDataIn,
	output logic        chipEnableN,
	output logic        outEnableN,
	output logic        writeEnableN
);
	if (BLC_CYCLES < 2 || GAP_CYCLES >= BLC_CYCLES ||
			WC_CYCLES < 1) begin
		$error("bad timing parameters");
	end
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_CMD = 3'b001, S_LOAD = 3'b011,
		S_WAIT = 3'b010, S_POLL = 3'b110, S_READ = 3'b111
	} state_t;
	state_t      state;
	bus_cycle_if cyc();
	logic [7:0]  dMeta, dSync;
	logic [2:0]  op;
	logic [17:0] base;
	logic [7:0]  single;
	logic [2:0]  cmdIdx;
	logic [8:0]  byteIdx;
	logic [31:0] timer;
	logic        issued;
	logic        havePrev;
	logic        prevBit;
	logic [7:0]  pendByte;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dMeta <= 8'h00;
			dSync <= 8'h00;
		end else begin
			dMeta <= flashDataIn;
			dSync <= dMeta;
		end
	end
	bus_cycle_engine engine (
		.clk          (clk),
		.rst          (rst),
		.cyc          (cyc.eng),
		.dataInSync   (dSync),
		.addrPin      (flashAddr),
		.dataOut      (flashDataOut),
		.dataOe       (flashDataOe),
		.chipEnableN  (chipEnableN),
		.outEnableN   (outEnableN),
		.writeEnableN (writeEnableN)
	);
	// Command words of each sequence: unlock prefix, opcode and boot select
	wire [2:0] cmdLen = (op == OP_BOOT_LO || op == OP_BOOT_HI) ? 3'h6 :
		(op == OP_PROG) ? 3'h0 : 3'h3;
	wire [7:0] opCode =
		(op == OP_PROT_ON)  ? CMD_PROT_ON :
		(op == OP_PROT_OFF) ? CMD_PROT_OFF :
		(op == OP_ID_IN)    ? CMD_ID_IN :
		(op == OP_ID_OUT)   ? CMD_ID_OUT : CMD_BOOT;
	wire [7:0] bootSel = (op == OP_BOOT_HI) ? CMD_BOOT_HI : CMD_BOOT_LO;
	wire [2:0] ci = cmdIdx;
	wire [14:0] cmdA = (ci == 3'h1 || ci == 3'h4) ? CMD_ADDR_B : CMD_ADDR_A;
	wire [7:0] cmdD = (ci == 3'h1 || ci == 3'h4) ? CMD_DATA_B :
		(ci == 3'h0 || ci == 3'h3) ? CMD_DATA_A :
		(ci == 3'h5) ? bootSel : opCode;
	wire loadsData = (op == OP_PROG || op == OP_PROT_ON || op == OP_PROT_OFF);
	wire [7:0] loadA = byteIdx[7:0];
	// Past the device's load window before the first status read
	wire timeUp = (timer >= 32'(BLC_CYCLES + GAP_CYCLES));
	wire wcOver = (timer >= 32'(WC_CYCLES));
	wire pollBit = cyc.rdata[TOGGLE_BIT];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= S_IDLE;
			op <= OP_READ;
			base <= '0;
			single <= 8'h00;
			cmdIdx <= 3'h0;
			byteIdx <= 9'h000;
			timer <= 32'h0;
			issued <= 1'b0;
			havePrev <= 1'b0;
			prevBit <= 1'b0;
			pendByte <= 8'h00;
			reqReady <= 1'b0;
			dataReq <= 1'b0;
			rspValid <= 1'b0;
			rspData <= 8'h00;
			rspTimeout <= 1'b0;
			cyc.start <= 1'b0;
			cyc.isWrite <= 1'b0;
			cyc.addr <= '0;
			cyc.wdata <= 8'h00;
		end else begin
			cyc.start <= 1'b0;
			rspValid <= 1'b0;
			dataReq <= 1'b0;
			reqReady <= (state == S_IDLE) && !reqValid;
			timer <= timer + 32'h1;
			case (state)
				S_IDLE: if (reqValid && reqReady) begin
					op <= reqOp;
					base <= reqAddr;
					single <= reqData;
					cmdIdx <= 3'h0;
					byteIdx <= 9'h000;
					issued <= 1'b0;
					reqReady <= 1'b0;
					rspTimeout <= 1'b0;
					state <= (reqOp == OP_READ) ? S_READ :
						(reqOp == OP_PROG) ? S_LOAD : S_CMD;
				end
				S_CMD: if (!issued) begin
					cyc.start <= 1'b1;
					cyc.isWrite <= 1'b1;
					cyc.addr <= {3'b000, cmdA};
					cyc.wdata <= cmdD;
					issued <= 1'b1;
				end else if (cyc.done) begin
					issued <= 1'b0;
					cmdIdx <= cmdIdx + 3'h1;
					if (cmdIdx + 3'h1 == cmdLen) begin
						timer <= 32'h0;
						byteIdx <= 9'h000;
						state <= loadsData ? S_LOAD : S_IDLE;
						rspValid <= !loadsData;
					end
				end
				S_LOAD: if (!issued) begin
					if (byteIdx == 9'(SECTOR_BYTES)) begin
						timer <= 32'h0;
						havePrev <= 1'b0;
						state <= S_WAIT;
					end else begin
						dataReq <= 1'b1;
						issued <= 1'b1;
						timer <= 32'h0;
					end
				end else if (dataReq) begin
					pendByte <= dataByte;
				end else if (!cyc.start && cyc.done == 1'b0 &&
						timer == 32'h2) begin
					cyc.start <= 1'b1;
					cyc.isWrite <= 1'b1;
					// Sector bits fixed, full 256 bytes
					cyc.addr <= {base[ADDR_W-1:SECTOR_LSB], loadA};
					cyc.wdata <= (op == OP_PROG && loadA != base[7:0]) ?
						pendByte : ((op == OP_PROG) ? single : pendByte);
				end else if (cyc.done) begin
					issued <= 1'b0;
					byteIdx <= byteIdx + 9'h001;
				end
				S_WAIT: if (timeUp) begin
					timer <= 32'h0;
					state <= S_POLL;
				end
				S_POLL: if (!issued) begin
					cyc.start <= 1'b1;
					cyc.isWrite <= 1'b0;
					cyc.addr <= base;
					issued <= 1'b1;
				end else if (cyc.done) begin
					issued <= 1'b0;
					havePrev <= 1'b1;
					prevBit <= pollBit;
					if (havePrev && pollBit == prevBit) begin
						rspValid <= 1'b1;
						state <= S_IDLE;
					end else if (wcOver) begin
						rspTimeout <= 1'b1;
						rspValid <= 1'b1;
						state <= S_IDLE;
					end
				end
				S_READ: if (!issued) begin
					cyc.start <= 1'b1;
					cyc.isWrite <= 1'b0;
					cyc.addr <= base;
					issued <= 1'b1;
				end else if (cyc.done) begin
					rspData <= cyc.rdata;
					rspValid <= 1'b1;
					issued <= 1'b0;
					state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end
	// Cycles since the previous sector byte strobe
	logic [31:0] sinceLoad;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			sinceLoad <= 32'h0;
		else if (state == S_LOAD && cyc.start)
			sinceLoad <= 32'h0;
		else
			sinceLoad <= sinceLoad + 32'h1;
	end
	chk_load_window: assert property (@(posedge clk) disable iff (rst)
		(state == S_LOAD && cyc.start && byteIdx != 9'h000) |->
		sinceLoad < 32'(BLC_CYCLES))
		else $error("byte load gap too long");
	chk_sector_hold: assert property (@(posedge clk) disable iff (rst)
		(state == S_LOAD && cyc.start) |->
		cyc.addr[17:8] == base[17:8])
		else $error("sector address moved");
	chk_poll_addr: assert property (@(posedge clk) disable iff (rst)
		(state == S_POLL && cyc.start) |-> cyc.addr == base)
		else $error("poll address changed");
	chk_cmd_range: assert property (@(posedge clk) disable iff (rst)
		(state == S_CMD && cyc.start) |-> cyc.addr[17:15] == 3'b000)
		else $error("command address too wide");
	chk_full_sector: assert property (@(posedge clk) disable iff (rst)
		(state == S_LOAD && $past(state) == S_LOAD) |=> byteIdx <= 9'h100)
		else $error("sector count overrun");
	cov_prog: cover property (@(posedge clk) state == S_POLL && rspValid);
	cov_read: cover property (@(posedge clk) state == S_READ && cyc.done);
	cov_cmd: cover property (@(posedge clk) state == S_CMD && cyc.done);
endmodule : sector_flash_host

// ### testbench/flash_model.sv
// Behavioural sector flash: commands, loads, toggle polling
`timescale 1ns/100ps
module flash_model
	import flash_host_pkg::*;
#(
	parameter int BLC = 150,
	parameter int WC = 600,
	parameter logic [7:0] MAKER = 8'h3C, // Arbitrary value
	parameter logic [7:0] DEVID = 8'hC3  // Arbitrary value
)(
	input  wire logic        clk,
	input  wire logic [17:0] addr,
	input  wire logic [7:0]  din,
	input  wire logic        ceN,
	input  wire logic        oeN,
	input  wire logic        weN,
	output logic [7:0]       dout
);
	logic [7:0]  mem [int];
	logic [7:0]  lat [int];
	logic [7:0]  last = 8'h00;
	logic        tog = 0, busy = 0, pend = 0, polled = 0;
	logic        idMode = 0;
	logic        prot = 0, armOn = 0, armOff = 0, bootLo = 0, bootHi = 0;
	logic [17:0] pollA, a;
	logic [9:0]  sec;
	int          step = 0, idle = 0, run = 0, loads = 0, faults = 0;
	wire         readOn = !ceN && !oeN;
	wire         wrStrobe = weN | ceN;
	logic        wrLow = 0;

	// Only a strobe that was really low counts, not the rise out of reset
	always @(negedge wrStrobe) wrLow = 1;

	// Command bytes are swallowed, other writes are sector loads unless protection is on and no protection change is armed
	always @(posedge wrStrobe) begin
		if (!busy && wrLow) begin
			if (step == 3) begin
				bootLo |= din == CMD_BOOT_LO;
				bootHi |= din == CMD_BOOT_HI;
				if (din == CMD_BOOT_LO || din == CMD_BOOT_HI)
					step = 0;
			end else if (step == 0 && addr[14:0] == CMD_ADDR_A
				&& din == CMD_DATA_A)
				step = 1;
			else if (step == 1 && addr[14:0] == CMD_ADDR_B
				&& din == CMD_DATA_B)
				step = 2;
			else if (step == 2) begin
				armOn = din == CMD_PROT_ON;
				armOff = din == CMD_PROT_OFF;
				idMode = din == CMD_ID_IN;
				step = din == CMD_BOOT ? 3 : 0;
			end else begin
				step = 0;
				if (!prot || armOn || armOff) begin
					if (pend && addr[17:8] !== sec)
						faults++;
					if (!pend)
						loads = 0;
					sec = addr[17:8];
					lat[addr[7:0]] = din;
					loads++;
					pend = 1;
					idle = 0;
				end
			end
		end
		wrLow = 0;
	end

	// Load window lapses, then the sector is erased and programmed
	always @(posedge clk) begin
		idle++;
		if (pend && idle >= BLC) begin
			pend = 0;
			busy = 1;
			polled = 0;
			run = 0;
		end
		if (busy)
			run++;
		if (busy && run >= WC) begin
			for (int i = 0; i < 256; i++) begin
				a = {sec, i[7:0]};
				if (!(bootLo && a < 18'h02000) && !(bootHi && a >= 18'h3E000))
					mem[a] = lat.exists(i) ? lat[i] : ~i[7:0];
			end
			lat.delete();
			prot = armOn ? 1'b1 : armOff ? 1'b0 : prot;
			armOn = 0;
			armOff = 0;
			busy = 0;
		end
	end

	// Each status read flips the toggle bit
	always @(posedge readOn) begin
		if (busy) begin
			tog = !tog;
			if (polled && addr !== pollA)
				faults++;
			pollA = addr;
			polled = 1;
		end
	end

	always @(readOn, addr, busy, tog, idMode, last) begin
		if (!readOn)
			dout = ~last;
		else if (busy)
			dout = {~last[7], tog, last[5:0]};
		else if (idMode && addr[17:1] == 0)
			dout = addr[0] ? DEVID : MAKER;
		else
			dout = mem.exists(addr) ? mem[addr] : 8'hFF;
	end

	always @(negedge readOn) last = dout;
endmodule : flash_model

// ### testbench/testbench.sv
// Self-checking bench for the sector flash host
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fails++; \
	$display("[ERR] %s exp %0h got %0h", n, e, a); end end
module testbench
	import flash_host_pkg::*;
;
	logic        clk = 0, rst = 1, reqValid = 0;
	logic [2:0]  reqOp = 3'h0;
	logic [17:0] reqAddr = 18'h00000, base;
	logic [7:0]  reqData = 8'h00, dataByte = 8'h00, pick;
	logic        reqReady, dataReq, rspValid, rspTimeout;
	logic [7:0]  rspData, flashDataOut, devOut;
	logic [17:0] flashAddr;
	logic        flashDataOe, chipEnableN, outEnableN, writeEnableN;
	logic [31:0] seed = 32'h000032C0;
	logic [7:0]  expMem [int];
	int          fails = 0, num_checks = 0, idx = 0;
	wire  [7:0]  bus = flashDataOe ? flashDataOut : devOut;
	wire  [3:0]  pins = {chipEnableN, outEnableN, writeEnableN, flashDataOe};

	sector_flash_host #(.BLC_CYCLES(400), .GAP_CYCLES(200),
		.WC_CYCLES(4000)) dut (.clk(clk), .rst(rst),
		.reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr),
		.reqData(reqData), .reqReady(reqReady), .dataReq(dataReq),
		.dataByte(dataByte), .rspValid(rspValid), .rspData(rspData),
		.rspTimeout(rspTimeout), .flashAddr(flashAddr),
		.flashDataOut(flashDataOut), .flashDataOe(flashDataOe),
		.flashDataIn(bus), .chipEnableN(chipEnableN),
		.outEnableN(outEnableN), .writeEnableN(writeEnableN));
	flash_model #(.MAKER(8'h3C), .DEVID(8'hC3)) fm (.clk(clk),
		.addr(flashAddr), .din(bus), .ceN(chipEnableN),
		.oeN(outEnableN), .weN(writeEnableN), .dout(devOut));

	initial forever #4 clk = ~clk;

	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd

	// Put the byte on the input while the request stands
	always @(posedge clk) begin
		#1;
		if (dataReq) begin
			dataByte = rnd();
			expMem[base + idx] = dataByte;
			idx++;
		end
	end

	task automatic stop_test();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	task automatic run(input logic [2:0] op, input logic [17:0] a);
		int n;
		n = 0;
		base = {a[17:8], 8'h00};
		idx = 0;
		@(posedge clk);
		#1 reqValid = 1;
		reqOp = op;
		reqAddr = a;
		reqData = rnd();
		do @(negedge clk); while (reqReady !== 1'b1);
		@(posedge clk);
		#1 reqValid = 0;
		do begin
			@(negedge clk);
			n++;
		end while (rspValid !== 1'b1 && n < 40000);
		`CHK("done", 1'b1, rspValid)
		`CHK("timeout", 1'b0, rspTimeout)
		if (op == OP_PROG)
			expMem[a] = reqData;
	endtask : run

	task automatic rd(input logic [17:0] a, input logic [7:0] e);
		run(OP_READ, a);
		`CHK("read", e, rspData)
	endtask : rd

	initial begin
		repeat (2) @(posedge clk);
		`CHK("idle pins", 4'hE, pins)
		#1 rst = 0;
		run(OP_PROG, 18'h31234);
		`CHK("loads", 256, fm.loads)
		// Sector ends, the single byte and one random spot
		for (int i = 0; i < 4; i++) begin
			pick = (i == 0) ? 8'h00 : (i == 1) ? 8'h34 :
				(i == 2) ? 8'hFF : rnd();
			rd({10'h312, pick}, expMem[{10'h312, pick}]);
		end
		run(OP_PROT_ON, 18'h0C300);
		`CHK("prot on", 1'b1, fm.prot)
		`CHK("loads", 256, fm.loads)
		rd(18'h0C3FF, expMem[18'h0C3FF]);
		run(OP_PROT_OFF, 18'h1E500);
		`CHK("prot off", 1'b0, fm.prot)
		rd(18'h1E500, expMem[18'h1E500]);
		run(OP_ID_IN, 18'h00000);
		rd(18'h00000, 8'h3C);
		rd(18'h00001, 8'hC3);
		run(OP_ID_OUT, 18'h00000);
		rd(18'h31234, expMem[18'h31234]);
		run(OP_BOOT_LO, 18'h00000);
		run(OP_BOOT_HI, 18'h3FFFF);
		`CHK("boot", 2'h3, {fm.bootLo, fm.bootHi})
		`CHK("faults", 0, fm.faults)
		stop_test();
	end

	initial begin
		repeat (95000) @(posedge clk);
		fails++;
		stop_test();
	end
endmodule : testbench
